/* src/plc_defs.svh */
// Register offsets, field positions, reset values and timing figures
`ifndef PLC_DEFS_SVH
`define PLC_DEFS_SVH
`define PLC_CTRL_OFS 8'h00
`define PLC_STAT_OFS 8'h04
`define PLC_RXCNT_OFS 8'h08
`define PLC_CTRL_RX_BIT 0
`define PLC_CTRL_TX_BIT 1
`define PLC_STAT_OVR_BIT 6
`define PLC_CTRL_RX_RST 1'b1
`define PLC_CTRL_TX_RST 1'b1
`define PLC_LEGACY_LCLK_KHZ 49152
`define PLC_NEWER_LCLK_KHZ 98304
`define PLC_AXI_OKAY 2'h0
`define PLC_AXI_DECERR 2'h3
`endif

/* src/plc_pkg.sv */
// Types shared by the link and port mode controller
package plc_pkg;
	typedef enum logic [2:0] {
		PLC_S100  = 3'b000,
		PLC_S200  = 3'b001,
		PLC_S400  = 3'b010,
		PLC_S400B = 3'b011,
		PLC_S800  = 3'b100
	} plc_speed_t;
	typedef enum logic [0:0] {
		PLC_TX_IDLE  = 1'b0,
		PLC_TX_SHIFT = 1'b1
	} plc_tx_st_t;
	typedef struct packed {
		logic [7:0]  awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [7:0]  araddr;
		logic        arvalid;
		logic        rready;
	} plc_axi_req_t;
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} plc_axi_rsp_t;
	typedef struct packed {
		logic       sel;
		logic       pll_stop;
		logic [2:0] force_ds;
		logic [2:0] remote_newer;
		logic [2:0] active;
		logic       frame;
		logic       strobe;
		logic       dbit;
		logic [1:0] src;
		plc_speed_t speed;
	} plc_pins_t;
	typedef struct packed {
		logic       newer;
		logic [2:0] force_ds;
		logic [2:0] remote_newer;
	} plc_cfg_t;
	typedef struct packed {
		plc_axi_rsp_t ax;
		logic         aw_got;
		logic         w_got;
		logic [7:0]   awa;
		logic [31:0]  wd;
		logic [3:0]   ws;
		logic         ctrl_rx;
		logic         ctrl_tx;
		logic         overrun;
		logic [15:0]  rxcnt;
		plc_pins_t    s1;
		plc_pins_t    s2;
		logic         strobe_d;
		plc_cfg_t     cfg;
		logic [1:0]   lcnt;
		logic         lclk;
		plc_tx_st_t   tx_st;
		logic [7:0]   tx_sh;
		logic [3:0]   tx_left;
		logic         tx_rdy;
		logic         tx_bv;
		logic         tx_bit;
		logic [2:0]   tx_pe;
		logic [7:0]   rx_sh;
		logic [3:0]   rx_cnt;
		logic [7:0]   b0;
		logic [7:0]   b1;
		logic [1:0]   bcnt;
		logic         rx_v;
		logic [2:0]   rpt_en;
		logic [2:0]   rpt_bit;
		logic [2:0]   beta;
		logic         boss;
	} plc_state_t;
	function automatic logic [3:0] plc_width(input plc_speed_t sp, input logic nw);
		if (nw) begin
			return 4'h8;
		end
		case (sp)
			PLC_S100: return 4'h2;
			PLC_S200: return 4'h4;
			default: return 4'h8;
		endcase
	endfunction : plc_width
endpackage : plc_pkg

/* src/plc_ctrl.sv */
// Link protocol, link clock, word widening and narrowing, port mode and repeat control
//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Legacy link mode: link clock at half the newer rate, rx words handed out on aclk, not retimed to it.
// - Newer link mode: link clock at the full reference rate.
// - Link hands 2, 4 or 8 bit words; device latches and shifts them out.
// - Five line rate codes: S100, S200, S400, S400B, S800.
// - Protocol select low runs the link interface in legacy mode.
// - Protocol select high runs the link interface in newer mode.
// - Protocol select never picks cable mode; low disables BOSS arbitration.
// - Port facing a legacy device uses data-strobe signalling at S100 to S400.
// - Bilingual port facing a newer node uses newer cable signalling.
// - Bilingual port mode follows the remote capability, no outside choice.
// - Received bits are widened per speed and mode, retimed, given to link.
// - Received packet is repeated on every other connected, active port.
// - Power-down high stops the PLL and all internally made clocks.
// - Each port can be forced to legacy-only signalling.
// - Force input low means bilingual, high means legacy-only.
`timescale 1ns/1ns
`default_nettype none
`include "plc_defs.svh"
module plc_ctrl #(
	parameter int PORTS = 3
) (
	input  wire  logic                aclk,
	input  wire  logic                aresetn,
	input  wire  plc_pkg::plc_axi_req_t axi_req,
	output var   plc_pkg::plc_axi_rsp_t axi_rsp,
	input  wire  logic                link_protocol_select,
	input  wire  logic                pll_stop_input,
	input  wire  logic                port0_legacy_force,
	input  wire  logic                port1_legacy_force,
	input  wire  logic                port2_legacy_force,
	input  wire  logic [2:0]          remote_newer,
	input  wire  logic [2:0]          port_active,
	input  wire  logic                rx_frame,
	input  wire  logic                rx_strobe,
	input  wire  logic                rx_data,
	input  wire  logic [1:0]          rx_src,
	input  wire  logic [2:0]          rx_speed,
	input  wire  logic [7:0]          tx_word,
	input  wire  plc_pkg::plc_speed_t tx_speed,
	input  wire  logic                tx_valid,
	output logic                      tx_ready,
	output logic                      tx_bit,
	output logic                      tx_bit_valid,
	output logic [2:0]                tx_port_en,
	output logic [7:0]                rx_word,
	output logic                      rx_valid,
	input  wire  logic                rx_ready,
	output logic                      link_clk,
	output logic                      link_mode_newer,
	output logic                      boss_enable,
	output logic [2:0]                port_beta,
	output logic [2:0]                rpt_en,
	output logic [2:0]                rpt_bit
);
	import plc_pkg::*;

	if (PORTS != 3) begin : g_bad_ports
		$error("plc_ctrl serves exactly three ports");
	end

	localparam logic [1:0] LEG_HALF = 2'(`PLC_NEWER_LCLK_KHZ / `PLC_LEGACY_LCLK_KHZ);

	plc_state_t st;
	plc_state_t n;
	plc_pins_t  pins;
	logic       busy;
	logic       run;
	logic       rx_go;
	logic [1:0] half;
	logic [3:0] rx_w;
	logic [7:0] rx_nw;
	logic [31:0] rd_val;

	assign pins = '{sel: link_protocol_select, pll_stop: pll_stop_input,
		force_ds: {port2_legacy_force, port1_legacy_force, port0_legacy_force},
		remote_newer: remote_newer, active: port_active, frame: rx_frame,
		strobe: rx_strobe, dbit: rx_data, src: rx_src, speed: plc_speed_t'(rx_speed)};

	// Packet in progress on either path
	assign busy = st.s2.frame || (st.tx_st == PLC_TX_SHIFT);
	assign run = !st.s2.pll_stop;
	assign half = st.cfg.newer ? 2'h1 : LEG_HALF;
	assign rx_go = st.s2.strobe && !st.strobe_d && st.s2.frame && st.ctrl_rx && run;
	assign rx_w = plc_width(st.s2.speed, st.cfg.newer);
	assign rx_nw = st.rx_sh | (8'(st.s2.dbit) << st.rx_cnt[2:0]);
	assign rd_val = (st.ax.arready && axi_req.araddr == `PLC_CTRL_OFS) ? {30'h0, st.ctrl_tx, st.ctrl_rx} :
		(axi_req.araddr == `PLC_STAT_OFS) ? {25'h0, st.overrun, !run, st.beta, st.boss, st.cfg.newer} :
		(axi_req.araddr == `PLC_RXCNT_OFS) ? {16'h0, st.rxcnt} : 32'h0;

	//////////////////////////////////////////////////////////////////////////////
	always_comb begin
		n = st;
		n.s1 = pins;
		n.s2 = st.s1;
		n.strobe_d = st.s2.strobe;

		// Static configuration, only taken between packets
		if (!busy) begin
			n.cfg.newer = st.s2.sel;
			n.cfg.force_ds = st.s2.force_ds;
			n.cfg.remote_newer = st.s2.remote_newer;
		end
		for (int i = 0; i < 3; i++) begin
			// Forced or legacy remote falls back to data-strobe, S100 to S400
			n.beta[i] = !st.cfg.force_ds[i] && st.cfg.remote_newer[i];
		end
		n.boss = st.cfg.newer;

		// Link clock divider, held low while the PLL is stopped
		if (!run) begin
			n.lclk = 1'b0;
			n.lcnt = 2'h0;
		end else if (st.lcnt >= half - 2'h1) begin
			n.lclk = !st.lclk;
			n.lcnt = 2'h0;
		end else begin
			n.lcnt = st.lcnt + 2'h1;
		end

		// Transmit narrowing
		n.tx_bv = 1'b0;
		n.tx_pe = st.s2.active & {3{run}};
		case (st.tx_st)
			PLC_TX_IDLE: begin
				if (tx_valid && st.tx_rdy) begin
					n.tx_sh = tx_word;
					n.tx_left = plc_width(tx_speed, st.cfg.newer);
					n.tx_st = PLC_TX_SHIFT;
					n.tx_rdy = 1'b0;
				end else begin
					n.tx_rdy = st.ctrl_tx && run;
				end
			end
			PLC_TX_SHIFT: begin
				if (run) begin
					n.tx_bit = st.tx_sh[0];
					n.tx_sh = st.tx_sh >> 1;
					n.tx_bv = 1'b1;
					n.tx_left = st.tx_left - 4'h1;
					if (st.tx_left == 4'h1) begin
						n.tx_st = PLC_TX_IDLE;
						n.tx_rdy = st.ctrl_tx;
					end
				end
			end
			default: begin
				n.tx_st = PLC_TX_IDLE;
			end
		endcase

		// AXI write
		if (st.ax.awready && axi_req.awvalid) begin
			n.aw_got = 1'b1;
			n.awa = axi_req.awaddr;
		end
		if (st.ax.wready && axi_req.wvalid) begin
			n.w_got = 1'b1;
			n.wd = axi_req.wdata;
			n.ws = axi_req.wstrb;
		end
		if (st.ax.bvalid && axi_req.bready) begin
			n.ax.bvalid = 1'b0;
		end
		if (st.aw_got && st.w_got && !st.ax.bvalid) begin
			n.aw_got = 1'b0;
			n.w_got = 1'b0;
			n.ax.bvalid = 1'b1;
			n.ax.bresp = `PLC_AXI_OKAY;
			if (st.awa == `PLC_CTRL_OFS) begin
				if (st.ws[0]) begin
					n.ctrl_rx = st.wd[`PLC_CTRL_RX_BIT];
					n.ctrl_tx = st.wd[`PLC_CTRL_TX_BIT];
				end
			end else if (st.awa == `PLC_STAT_OFS) begin
				if (st.ws[0] && st.wd[`PLC_STAT_OVR_BIT]) begin
					n.overrun = 1'b0;
				end
			end else if (st.awa == `PLC_RXCNT_OFS) begin
				n.ax.bresp = `PLC_AXI_OKAY;
			end else begin
				n.ax.bresp = `PLC_AXI_DECERR;
			end
		end
		n.ax.awready = !n.aw_got && !n.ax.bvalid;
		n.ax.wready = !n.w_got && !n.ax.bvalid;

		// AXI read
		if (st.ax.rvalid && axi_req.rready) begin
			n.ax.rvalid = 1'b0;
		end
		if (st.ax.arready && axi_req.arvalid) begin
			n.ax.rvalid = 1'b1;
			n.ax.rdata = rd_val;
			if (axi_req.araddr == `PLC_CTRL_OFS || axi_req.araddr == `PLC_STAT_OFS ||
				axi_req.araddr == `PLC_RXCNT_OFS) begin
				n.ax.rresp = `PLC_AXI_OKAY;
			end else begin
				n.ax.rresp = `PLC_AXI_DECERR;
			end
		end
		n.ax.arready = !n.ax.rvalid;

		// Receive widening into the two-entry buffer
		if (st.rx_v && rx_ready) begin
			n.b0 = st.b1;
			n.bcnt = st.bcnt - 2'h1;
			n.rxcnt = st.rxcnt + 16'h1;
		end
		if (!st.s2.frame) begin
			n.rx_cnt = 4'h0;
			n.rx_sh = 8'h0;
		end else if (rx_go) begin
			if (n.bcnt == 2'h2) begin
				// Full buffer stalls the widener; the bit is lost and flagged
				n.overrun = 1'b1;
			end else if (st.rx_cnt + 4'h1 == rx_w) begin
				if (n.bcnt == 2'h0) begin
					n.b0 = rx_nw;
				end else begin
					n.b1 = rx_nw;
				end
				n.bcnt = n.bcnt + 2'h1;
				n.rx_cnt = 4'h0;
				n.rx_sh = 8'h0;
			end else begin
				n.rx_sh = rx_nw;
				n.rx_cnt = st.rx_cnt + 4'h1;
			end
		end
		n.rx_v = n.bcnt != 2'h0;

		// Repeat onto the other active ports
		for (int i = 0; i < 3; i++) begin
			n.rpt_en[i] = st.s2.frame && st.s2.active[i] && (st.s2.src != 2'(i)) && run;
			n.rpt_bit[i] = st.s2.dbit;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
			st.ctrl_rx <= `PLC_CTRL_RX_RST;
			st.ctrl_tx <= `PLC_CTRL_TX_RST;
		end else begin
			st <= n;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	assign axi_rsp = st.ax;
	assign tx_ready = st.tx_rdy;
	assign tx_bit = st.tx_bit;
	assign tx_bit_valid = st.tx_bv;
	assign tx_port_en = st.tx_pe;
	assign rx_word = st.b0;
	assign rx_valid = st.rx_v;
	assign link_clk = st.lclk;
	assign link_mode_newer = st.cfg.newer;
	assign boss_enable = st.boss;
	assign port_beta = st.beta;
	assign rpt_en = st.rpt_en;
	assign rpt_bit = st.rpt_bit;

	//////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_LEGACY_CLK: assert property (
		$rose(link_clk) && !link_mode_newer && run |=> link_clk ##1 !link_clk)
		else $error("legacy link clock half period is not two cycles");
	AST_NEWER_CLK: assert property (
		link_clk && link_mode_newer && run |=> !link_clk)
		else $error("newer link clock half period is not one cycle");
	AST_TX_S100: assert property (
		tx_valid && tx_ready && tx_speed == PLC_S100 && !link_mode_newer && run
		|-> ##2 tx_bit_valid[*2] ##1 !tx_bit_valid)
		else $error("two-bit word not sent as two bits");
	AST_TX_NEWER: assert property (
		tx_valid && tx_ready && link_mode_newer && run |-> ##2 tx_bit_valid[*8])
		else $error("newer mode word not sent as eight bits");
	AST_BOSS_OFF: assert property (
		!busy && !st.s2.sel ##1 !busy |=> !boss_enable)
		else $error("BOSS enabled with legacy link select");
	AST_FORCE_DS: assert property (
		!busy && st.s2.force_ds[0] ##1 !busy |=> !port_beta[0])
		else $error("forced port runs newer signalling");
	AST_BILINGUAL: assert property (
		!busy && !st.s2.force_ds[1] && st.s2.remote_newer[1] ##1 !busy |=> port_beta[1])
		else $error("bilingual port did not follow remote capability");
	AST_REPEAT: assert property (
		rpt_en[0] |-> $past(st.s2.src) != 2'h0 && $past(st.s2.frame))
		else $error("packet repeated onto its own source port");
	AST_PLL_STOP: assert property (
		st.s2.pll_stop |=> !link_clk && !tx_bit_valid && rpt_en == 3'h0)
		else $error("clocks run while the PLL is stopped");
	AST_CFG_HOLD: assert property (
		busy |=> $stable(st.cfg))
		else $error("configuration changed during a packet");
	AST_RX_HOLD: assert property (
		rx_valid && !rx_ready |=> rx_valid && $stable(rx_word))
		else $error("receive word lost under stall");

	// Link mode follows the select between packets
	AST_LINK_NEWER: assert property (
		!busy && st.s2.sel |=> link_mode_newer)
		else $error("newer link select not taken between packets");
	AST_LINK_LEGACY: assert property (
		!busy && !st.s2.sel |=> !link_mode_newer)
		else $error("legacy link select not taken between packets");

	// Word lengths for the wider legacy speeds
	AST_TX_S200: assert property (
		tx_valid && tx_ready && tx_speed == PLC_S200 && !link_mode_newer && run
		|-> ##2 tx_bit_valid[*4] ##1 !tx_bit_valid)
		else $error("four-bit word not sent as four bits");
	AST_TX_S400B: assert property (
		tx_valid && tx_ready && tx_speed == PLC_S400B && !link_mode_newer && run
		|-> ##2 tx_bit_valid[*8] ##1 !tx_bit_valid)
		else $error("S400B word not sent as eight bits");
	AST_TX_S800: assert property (
		tx_valid && tx_ready && tx_speed == PLC_S800 && !link_mode_newer && run
		|-> ##2 tx_bit_valid[*8] ##1 !tx_bit_valid)
		else $error("S800 word not sent as eight bits");
	AST_LEGACY_REMOTE: assert property (
		!busy && !st.s2.remote_newer[2] ##1 !busy |=> !port_beta[2])
		else $error("port facing a legacy device runs newer signalling");
	AST_REPEAT_ON: assert property (
		st.s2.frame && st.s2.active[2] && st.s2.src != 2'h2 && run |=> rpt_en[2])
		else $error("packet not repeated onto an active port");
	AST_REPEAT_BIT: assert property (
		rpt_en[2] |-> rpt_bit[2] == $past(st.s2.dbit))
		else $error("repeated bit differs from received bit");

	COV_TX: cover property (tx_valid && tx_ready ##2 tx_bit_valid);
	COV_RX: cover property (!rx_valid ##1 rx_valid);
	COV_BETA: cover property ($rose(port_beta[2]));
	COV_AXW: cover property (axi_rsp.bvalid && axi_req.bready);
	COV_RPT: cover property (rpt_en[2] && rpt_bit[2]);
endmodule : plc_ctrl
`default_nettype wire

/* tb/plc_link_model.sv */
// Link-layer controller model: offers transmit words and takes receive words
`timescale 1ns/1ns
`default_nettype none
module plc_link_model (
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic                send,
	input  wire logic [7:0]          word_in,
	input  wire plc_pkg::plc_speed_t speed_in,
	input  wire logic                stall,
	input  wire logic                tx_ready,
	output var  logic [7:0]          tx_word,
	output var  plc_pkg::plc_speed_t tx_speed,
	output var  logic                tx_valid,
	output var  logic                rx_ready
);
	import plc_pkg::*;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_valid <= 1'b0;
			tx_word  <= 8'h00;
			tx_speed <= PLC_S100;
			rx_ready <= 1'b0;
		end else begin
			rx_ready <= !stall;
			if (send) begin
				tx_valid <= 1'b1;
				tx_word  <= word_in;
				tx_speed <= speed_in;
			end else if (tx_valid && tx_ready) begin
				tx_valid <= 1'b0;
				// Released word no longer holds its value
				tx_word  <= ~tx_word;
			end
		end
	end
endmodule : plc_link_model
`default_nettype wire

/* tb/plc_ctrl_tb.sv */
// Self-checking bench for the link and port mode controller
`timescale 1ns/1ns
`default_nettype none
module plc_ctrl_tb;
	import plc_pkg::*;
	logic         aclk, aresetn, sel, pstop, f0, f1, f2, frm, stb, dat, send, stall;
	logic [2:0]   rnew, act, rspd, tx_port_en, port_beta, rpt_en, rpt_bit;
	logic [1:0]   src, r;
	logic [7:0]   wrd, tx_word, rx_word, w0, w1;
	logic [31:0]  d;
	logic         tx_valid, tx_ready, tx_bit, tx_bit_valid, rx_valid, rx_ready, link_clk, newer, boss;
	plc_speed_t   spd, tx_speed;
	plc_axi_req_t ax;
	plc_axi_rsp_t rs;
	logic [7:0]   rxq[$];
	int           err_total, num_checks;
	plc_ctrl #(.PORTS(3)) dut (.aclk(aclk), .aresetn(aresetn), .axi_req(ax), .axi_rsp(rs),
		.link_protocol_select(sel), .pll_stop_input(pstop), .port0_legacy_force(f0), .port1_legacy_force(f1),
		.port2_legacy_force(f2), .remote_newer(rnew), .port_active(act), .rx_frame(frm), .rx_strobe(stb),
		.rx_data(dat), .rx_src(src), .rx_speed(rspd), .tx_word(tx_word), .tx_speed(tx_speed),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid),
		.tx_port_en(tx_port_en), .rx_word(rx_word), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.link_clk(link_clk), .link_mode_newer(newer), .boss_enable(boss), .port_beta(port_beta),
		.rpt_en(rpt_en), .rpt_bit(rpt_bit));
	plc_link_model lnk (.aclk(aclk), .aresetn(aresetn), .send(send), .word_in(wrd), .speed_in(spd),
		.stall(stall), .tx_ready(tx_ready), .tx_word(tx_word), .tx_speed(tx_speed), .tx_valid(tx_valid),
		.rx_ready(rx_ready));
	//////////////////////////////////////////////////////////////////////////////
	function automatic int wid(input plc_speed_t s, input logic nw);
		if (nw || s > PLC_S200)
			return 8;
		return (s == PLC_S100) ? 2 : 4;
	endfunction : wid
	task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : complete_run
	task automatic rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rv);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		ax.araddr <= a;
		ax.arvalid <= 1'b1;
		ax.rready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (rs.arready)
				ax.arvalid <= 1'b0;
			if (rs.rvalid) begin
				dv = rs.rdata;
				rv = rs.rresp;
				ax.rready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] dv, output logic [1:0] rv);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		ax.awaddr <= a;
		ax.wdata <= dv;
		ax.wstrb <= 4'hF;
		ax.awvalid <= 1'b1;
		ax.wvalid <= 1'b1;
		ax.bready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (rs.awready)
				ax.awvalid <= 1'b0;
			if (rs.wready)
				ax.wvalid <= 1'b0;
			if (rs.bvalid) begin
				rv = rs.bresp;
				ax.bready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : wr
	task automatic clkrate(input int exp);
		logic pv;
		int   n;
		n = 0;
		@(negedge aclk);
		pv = link_clk;
		repeat (16) begin
			@(negedge aclk);
			if (link_clk === 1'b1 && pv === 1'b0)
				n++;
			pv = link_clk;
		end
		chk("link_clk_rises", n, exp);
	endtask : clkrate
	task automatic txword(input logic [7:0] w, input plc_speed_t s, input logic nw);
		logic [7:0] got;
		int         k;
		got = 8'h00;
		k = 0;
		@(posedge aclk);
		wrd <= w;
		spd <= s;
		send <= 1'b1;
		@(posedge aclk);
		send <= 1'b0;
		repeat (30) begin
			@(negedge aclk);
			if (tx_bit_valid === 1'b1 && k < 8) begin
				got[k] = tx_bit;
				k++;
			end
		end
		chk("tx_bits", k, wid(s, nw));
		chk("tx_word", got, w & (8'hFF >> (8 - wid(s, nw))));
		chk("tx_ready", tx_ready, 1'b1);
	endtask : txword
	task automatic rxword(input logic [7:0] w, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge aclk);
			dat <= w[i];
			repeat (3) @(posedge aclk);
			stb <= 1'b1;
			repeat (4) @(posedge aclk);
			stb <= 1'b0;
		end
		repeat (8) @(posedge aclk);
	endtask : rxword
	task automatic rxone(input logic [7:0] w, input int n);
		rxword(w, n);
		chk("rx_cnt", rxq.size(), 1);
		if (rxq.size() > 0)
			chk("rx_word", rxq.pop_front(), w & (8'hFF >> (8 - n)));
	endtask : rxone
	always @(posedge aclk)
		if (rx_valid === 1'b1 && rx_ready === 1'b1)
			rxq.push_back(rx_word);
	//////////////////////////////////////////////////////////////////////////////
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	initial begin
		repeat (40000) @(posedge aclk);
		err_total++;
		complete_run();
	end
	initial begin
		{aresetn, sel, pstop, f0, f1, f2, frm, stb, dat, send, stall} = '0;
		{rnew, rspd, src, wrd, d, w0, w1} = '0;
		act = 3'h7;
		spd = PLC_S100;
		ax = '0;
		err_total = 0;
		num_checks = 0;
		void'($urandom(32'h5384));
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (6) @(posedge aclk);
		rd(8'h00, d, r);
		chk("ctrl", {r, d}, 34'h3);
		rd(8'h04, d, r);
		chk("mode_boss", d[1:0], 2'h0);
		rd(8'h0C, d, r);
		chk("rresp", r, 2'h3);
		wr(8'h10, 32'h0, r);
		chk("bresp", r, 2'h3);
		clkrate(4);
		$display("registers and legacy clock done");
		for (int s = 0; s < 5; s++)
			txword(8'($urandom), plc_speed_t'(s[2:0]), 1'b0);
		wr(8'h00, 32'h1, r);
		repeat (4) @(negedge aclk);
		chk("tx_ready_off", tx_ready, 1'b0);
		wr(8'h00, 32'h3, r);
		$display("transmit done");
		for (int i = 0; i < 4; i++) begin
			{f2, f1, f0} <= 3'($urandom);
			rnew <= 3'($urandom);
			act <= 3'($urandom);
			repeat (8) @(posedge aclk);
			@(negedge aclk);
			chk("port_beta", port_beta, ~{f2, f1, f0} & rnew);
			chk("tx_port_en", tx_port_en, act);
		end
		rd(8'h04, d, r);
		chk("stat_beta", d[4:2], ~{f2, f1, f0} & rnew);
		$display("port mode done");
		act <= act | 3'h5;
		src <= 2'($urandom % 2);
		dat <= 1'($urandom);
		frm <= 1'b1;
		repeat (8) @(posedge aclk);
		@(negedge aclk);
		chk("rpt_en", rpt_en, act & ~(3'h1 << src));
		chk("rpt_bit", rpt_bit, {3{dat}});
		for (int s = 0; s < 5; s++) begin
			rspd <= 3'(s);
			rxone(8'($urandom), wid(plc_speed_t'(s[2:0]), 1'b0));
		end
		w0 = 8'($urandom);
		w1 = ~w0;
		rspd <= PLC_S100;
		stall <= 1'b1;
		rxword(w0, 2);
		rxword(w1, 2);
		rxword(w0 ^ 8'h3, 2);
		rd(8'h04, d, r);
		chk("overrun", d[6], 1'b1);
		stall <= 1'b0;
		repeat (8) @(posedge aclk);
		chk("rx_held", rxq.size(), 2);
		chk("rx_first", rxq[0], w0 & 8'h3);
		chk("rx_second", rxq[1], w1 & 8'h3);
		rxq.delete();
		rd(8'h08, d, r);
		chk("rxcnt", d[15:0], 16'h7);
		wr(8'h04, 32'h40, r);
		rd(8'h04, d, r);
		chk("overrun_clr", d[6], 1'b0);
		$display("receive done");
		frm <= 1'b0;
		sel <= 1'b1;
		repeat (8) @(posedge aclk);
		@(negedge aclk);
		chk("newer", {newer, boss}, 2'h3);
		clkrate(8);
		txword(8'($urandom), PLC_S100, 1'b1);
		frm <= 1'b1;
		repeat (6) @(posedge aclk);
		sel <= 1'b0;
		rxone(8'($urandom), 8);
		chk("newer_held", newer, 1'b1);
		frm <= 1'b0;
		repeat (8) @(posedge aclk);
		@(negedge aclk);
		chk("legacy", {newer, boss}, 2'h0);
		$display("mode switch done");
		pstop <= 1'b1;
		repeat (8) @(posedge aclk);
		clkrate(0);
		chk("pll_port_en", tx_port_en, 3'h0);
		rd(8'h04, d, r);
		chk("pll_stat", d[5], 1'b1);
		pstop <= 1'b0;
		$display("power down done");
		complete_run();
	end
endmodule : plc_ctrl_tb
`default_nettype wire
